// file: irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// Register offsets on the plain register port
`define OFS_EDGE_PRIO_CTRL   3'h0
`define OFS_EXT_PIN_CTRL     3'h1
`define OFS_RESET_PRIO_STAT  3'h2
`define OFS_PERIPH_FLAGS_1   3'h3
`define OFS_PERIPH_FLAGS_2   3'h4
`define OFS_CORE_IRQ_CTRL    3'h5

// Edge and priority control fields
`define BIT_PULLUP_DISABLE   7
`define BIT_PIN0_EDGE        6
`define BIT_PIN1_EDGE        5
`define BIT_PIN2_EDGE        4
`define BIT_TMR0_PRIO        2
`define BIT_PORTCHG_PRIO     0
`define MASK_EDGE_PRIO_CTRL  8'hF5
`define RST_EDGE_PRIO_CTRL   8'hF5

// External pin control fields
`define BIT_PIN2_PRIO        7
`define BIT_PIN1_PRIO        6
`define BIT_PIN2_EN          4
`define BIT_PIN1_EN          3
`define BIT_PIN2_FLAG        1
`define BIT_PIN1_FLAG        0
`define MASK_EXT_PIN_CTRL    8'hDB
`define RST_EXT_PIN_CTRL     8'hC0

// Reset and priority status fields
`define BIT_PRIO_LEVELS_EN   7
`define MASK_RESET_PRIO_STAT 8'hDF
`define RST_RESET_PRIO_STAT  8'h1C

// Peripheral flag fields
`define BIT_RX_FULL          5
`define BIT_TX_EMPTY         4
`define MASK_PERIPH_FLAGS_2  8'h0F

// Core interrupt control fields
`define BIT_GLOBAL_EN        7
`define BIT_PERIPH_GLOBAL_EN 6
`define BIT_TMR0_EN          5
`define BIT_PIN0_EN          4
`define BIT_PORTCHG_EN       3
`define BIT_TMR0_FLAG        2
`define BIT_PIN0_FLAG        1
`define BIT_PORTCHG_FLAG     0
`define RST_CORE_IRQ_CTRL    8'h00

// Vector addresses
`define VEC_HIGH             21'h000008
`define VEC_LOW              21'h000018

`endif

// file: irq_pkg.sv
package irq_pkg;

	typedef logic [7:0]  byte_t;
	typedef logic [2:0]  reg_addr_t;
	typedef logic [20:0] vec_addr_t;
	typedef logic [16:0] src_vec_t;

	// One register port request, all fields sampled in the same cycle
	typedef struct packed {
		reg_addr_t addr;
		byte_t     wdata;
		logic      wr;
		logic      rd;
	} bus_req_s;

	// Peripheral event inputs, pulses except the two serial levels
	typedef struct packed {
		logic psp_access;
		logic adc_done;
		logic rx_full;
		logic tx_empty;
		logic ssp_done;
		logic capture_a;
		logic timer2_match;
		logic timer1_ovf;
		logic bus_coll;
		logic low_volt;
		logic timer3_ovf;
		logic capture_b;
	} periph_evt_s;

endpackage

// file: ext_edge_detect.sv
`timescale 1ns/10ps
// Synchronises the three external pins and flags the selected edge
module ext_edge_detect (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] pin_i,
	input  wire logic [2:0] rising_sel_i,
	output logic      [2:0] edge_o
);

	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic [2:0] prev_q;
	logic [2:0] warm_q;

	// Two-flop synchroniser; first stage feeds only the second
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
		end
	end

	// Previous synchronised level for edge comparison
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			prev_q <= 3'h0;
		end else begin
			prev_q <= sync_q;
		end
	end

	// Edges stay masked until the compare flop holds a real pin level, so a
	// pin idling high cannot fake a rising edge just after reset
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			warm_q <= 3'h0;
		end else begin
			warm_q <= {warm_q[1:0], 1'b1};
		end
	end

	// Rising when select is 1, falling when 0
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			edge_o[i] = warm_q[2] & (rising_sel_i[i] ? (sync_q[i] & ~prev_q[i])
			                                         : (~sync_q[i] & prev_q[i]));
		end
	end

endmodule

// file: irq_request_arbiter.sv
`timescale 1ns/10ps
`include "irq_consts.svh"
// Combines flags, enables and priorities into high and low requests
module irq_request_arbiter (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_i,
	input  wire irq_pkg::src_vec_t   flag_i,
	input  wire irq_pkg::src_vec_t   enable_i,
	input  wire irq_pkg::src_vec_t   prio_high_i,
	input  wire irq_pkg::src_vec_t   is_periph_i,
	input  wire logic                prio_levels_i,
	input  wire logic                global_en_i,
	input  wire logic                periph_global_en_i,
	output logic                     irq_high_o,
	output logic                     irq_low_o,
	output irq_pkg::vec_addr_t       vector_o
);

	irq_pkg::src_vec_t pend;
	logic              high_d;
	logic              low_d;

	// Pending means flag and own enable both set
	assign pend = flag_i & enable_i;

	// Single-level mode ignores priorities and gates peripherals
	always_comb begin
		if (prio_levels_i) begin
			high_d = global_en_i & |(pend & prio_high_i);
			low_d  = global_en_i & periph_global_en_i
			       & |(pend & ~prio_high_i);
		end else begin
			high_d = global_en_i
			       & |(pend & (~is_periph_i | {17{periph_global_en_i}}));
			low_d  = 1'b0;
		end
	end

	// Registered outputs; high request overrides low for the vector
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_high_o <= 1'b0;
			irq_low_o  <= 1'b0;
			vector_o   <= `VEC_HIGH;
		end else begin
			irq_high_o <= high_d;
			irq_low_o  <= low_d & ~high_d;
			vector_o   <= (high_d | ~low_d) ? `VEC_HIGH : `VEC_LOW;
		end
	end

endmodule

// file: interrupt_edge_priority_flags.sv
`timescale 1ns/10ps
`include "irq_consts.svh"

// Summary of operation
// - Pull-up disable bit set turns off all pull-ups, else latch decides.
// - Edge bits 6,5,4 pick rising (1) or falling (0) for pins 0,1,2.
// - Bit 2 is timer0 overflow priority, bit 0 port-change priority.
// - Unimplemented bits read zero and ignore writes.
// - Pin 2 and pin 1 priority bits at 7 and 6, reset high.
// - Pin 2 and pin 1 enables at bits 4 and 3, reset low.
// - Pin 2 and pin 1 flags at bits 1 and 0 held until written zero.
// - Flags set on events regardless of any enable, allowing polling.
// - In single-level mode peripherals need the peripheral global enable.
// - Priority bits only matter while priority levels are enabled.
// - Reset-control bit 7 enables two priority levels, reset zero.
// - Reset-control layout: long write, reserved, cause flags, status bits.
// - Parallel port access sets flag-one bit 7 until software clears it.
// - Conversion done sets flag-one bit 6 until software clears it.
// - Flag-one bit 5 read-only, mirrors serial receive buffer full.
// - Flag-one bit 4 read-only, high while serial transmit buffer empty.
// - Synchronous serial done sets flag-one bit 3 until cleared.
// - Capture of timer1 sets flag-one bit 2 until cleared.
// - Flag-two upper nibble reads zero, lower nibble writable, reset zero.
// - Flag, enable, global enable and, for low or single-level peripheral requests, peripheral global enable vector high or low.
// - Flag-two bits: collision, low voltage, timer3 overflow, capture b.
module interrupt_edge_priority_flags (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_i,
	input  wire irq_pkg::bus_req_s    bus_i,
	output irq_pkg::byte_t            rd_data_o,
	input  wire logic [2:0]           ext_pin_i,
	input  wire logic                 timer0_ovf_i,
	input  wire logic                 port_change_i,
	input  wire irq_pkg::periph_evt_s periph_evt_i,
	input  wire logic [11:0]          periph_enable_i,
	input  wire logic [11:0]          periph_priority_i,
	input  wire logic [7:0]           port_b_latch_i,
	output logic      [7:0]           port_pullup_en_o,
	output logic                      irq_high_o,
	output logic                      irq_low_o,
	output irq_pkg::vec_addr_t        vector_addr_o
);

	irq_pkg::byte_t    edge_ctrl_q;
	irq_pkg::byte_t    pin_ctrl_q;
	irq_pkg::byte_t    reset_stat_q;
	irq_pkg::byte_t    pflags1_q;
	irq_pkg::byte_t    pflags2_q;
	irq_pkg::byte_t    core_ctrl_q;
	irq_pkg::byte_t    rd_d;
	logic [2:0]        pin_edge;
	logic [2:0]        rise_sel;
	logic              wr_edge;
	logic              wr_pin;
	logic              wr_reset;
	logic              wr_pf1;
	logic              wr_pf2;
	logic              wr_core;
	irq_pkg::byte_t    pf1_evt;
	irq_pkg::byte_t    pf2_evt;
	irq_pkg::byte_t    pin_evt;
	irq_pkg::byte_t    core_evt;
	irq_pkg::src_vec_t src_flag;
	irq_pkg::src_vec_t src_en;
	irq_pkg::src_vec_t src_prio;
	irq_pkg::src_vec_t src_periph;

	// Sticky flag update: software value on write, events always OR in
	function automatic irq_pkg::byte_t flag_next(
		input irq_pkg::byte_t cur,
		input irq_pkg::byte_t wdata,
		input logic           wr,
		input irq_pkg::byte_t evt,
		input irq_pkg::byte_t mask
	);
		irq_pkg::byte_t base;
		base = wr ? (wdata & mask) : (cur & mask);
		return base | (evt & mask);
	endfunction

	// Write strobes decoded per register
	function automatic logic wr_hit(
		input irq_pkg::bus_req_s req,
		input irq_pkg::reg_addr_t ofs
	);
		return req.wr && (req.addr == ofs);
	endfunction

	assign wr_edge  = wr_hit(bus_i, `OFS_EDGE_PRIO_CTRL);
	assign wr_pin   = wr_hit(bus_i, `OFS_EXT_PIN_CTRL);
	assign wr_reset = wr_hit(bus_i, `OFS_RESET_PRIO_STAT);
	assign wr_pf1   = wr_hit(bus_i, `OFS_PERIPH_FLAGS_1);
	assign wr_pf2   = wr_hit(bus_i, `OFS_PERIPH_FLAGS_2);
	assign wr_core  = wr_hit(bus_i, `OFS_CORE_IRQ_CTRL);

	// Edge select bits in pin order 2,1,0
	assign rise_sel = {edge_ctrl_q[`BIT_PIN2_EDGE],
	                   edge_ctrl_q[`BIT_PIN1_EDGE],
	                   edge_ctrl_q[`BIT_PIN0_EDGE]};

	// Pins pass a synchroniser before their edges are seen
	ext_edge_detect u_edge (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.pin_i       (ext_pin_i),
		.rising_sel_i(rise_sel),
		.edge_o      (pin_edge)
	);

	// Edge and priority control; reserved bits never stored
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			edge_ctrl_q <= `RST_EDGE_PRIO_CTRL;
		end else if (wr_edge) begin
			edge_ctrl_q <= bus_i.wdata & `MASK_EDGE_PRIO_CTRL;
		end
	end

	// Event vector for the pin control flags
	always_comb begin
		pin_evt                 = 8'h00;
		pin_evt[`BIT_PIN2_FLAG] = pin_edge[2];
		pin_evt[`BIT_PIN1_FLAG] = pin_edge[1];
	end

	// External pin control: priorities, enables and pin 1/2 flags
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_ctrl_q <= `RST_EXT_PIN_CTRL;
		end else begin
			pin_ctrl_q <= flag_next(pin_ctrl_q, bus_i.wdata, wr_pin, pin_evt,
			                        `MASK_EXT_PIN_CTRL);
		end
	end

	// Reset-cause bits are plain storage here; their causes live elsewhere
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			reset_stat_q <= `RST_RESET_PRIO_STAT;
		end else if (wr_reset) begin
			reset_stat_q <= bus_i.wdata & `MASK_RESET_PRIO_STAT;
		end
	end

	// Peripheral flag-one events; serial bits are handled separately
	always_comb begin
		pf1_evt    = 8'h00;
		pf1_evt[7] = periph_evt_i.psp_access;
		pf1_evt[6] = periph_evt_i.adc_done;
		pf1_evt[3] = periph_evt_i.ssp_done;
		pf1_evt[2] = periph_evt_i.capture_a;
		pf1_evt[1] = periph_evt_i.timer2_match;
		pf1_evt[0] = periph_evt_i.timer1_ovf;
	end

	// Sticky bits of flag-one plus mirrored serial buffer states
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pflags1_q <= 8'h00;
		end else begin
			pflags1_q <= flag_next(pflags1_q, bus_i.wdata, wr_pf1, pf1_evt,
			                       8'hCF);
			pflags1_q[`BIT_RX_FULL]  <= periph_evt_i.rx_full;
			pflags1_q[`BIT_TX_EMPTY] <= periph_evt_i.tx_empty;
		end
	end

	// Peripheral flag-two events in the lower nibble
	always_comb begin
		pf2_evt    = 8'h00;
		pf2_evt[3] = periph_evt_i.bus_coll;
		pf2_evt[2] = periph_evt_i.low_volt;
		pf2_evt[1] = periph_evt_i.timer3_ovf;
		pf2_evt[0] = periph_evt_i.capture_b;
	end

	// Upper nibble is never stored so it always reads zero
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pflags2_q <= 8'h00;
		end else begin
			pflags2_q <= flag_next(pflags2_q, bus_i.wdata, wr_pf2, pf2_evt,
			                       `MASK_PERIPH_FLAGS_2);
		end
	end

	// Core-side sources: timer0 overflow, pin 0, port change
	always_comb begin
		core_evt                    = 8'h00;
		core_evt[`BIT_TMR0_FLAG]    = timer0_ovf_i;
		core_evt[`BIT_PIN0_FLAG]    = pin_edge[0];
		core_evt[`BIT_PORTCHG_FLAG] = port_change_i;
	end

	// Global enables, core enables and their flags
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			core_ctrl_q <= `RST_CORE_IRQ_CTRL;
		end else begin
			core_ctrl_q <= flag_next(core_ctrl_q, bus_i.wdata, wr_core, core_evt,
			                         8'hFF);
		end
	end

	// Weak pull-ups: all off when disabled, else follow the port latch
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			port_pullup_en_o <= 8'h00;
		end else if (edge_ctrl_q[`BIT_PULLUP_DISABLE]) begin
			port_pullup_en_o <= 8'h00;
		end else begin
			port_pullup_en_o <= port_b_latch_i;
		end
	end

	// Read multiplexer; unmapped offsets answer zero
	always_comb begin
		unique case (bus_i.addr)
			`OFS_EDGE_PRIO_CTRL:  rd_d = edge_ctrl_q;
			`OFS_EXT_PIN_CTRL:    rd_d = pin_ctrl_q;
			`OFS_RESET_PRIO_STAT: rd_d = reset_stat_q;
			`OFS_PERIPH_FLAGS_1:  rd_d = pflags1_q;
			`OFS_PERIPH_FLAGS_2:  rd_d = pflags2_q;
			`OFS_CORE_IRQ_CTRL:   rd_d = core_ctrl_q;
			default:              rd_d = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the read strobe
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h00;
		end else begin
			rd_data_o <= bus_i.rd ? rd_d : 8'h00;
		end
	end

	// Source vectors: [16:12] core and pins, [11:0] peripherals
	assign src_flag = {core_ctrl_q[`BIT_TMR0_FLAG],
	                   core_ctrl_q[`BIT_PIN0_FLAG],
	                   core_ctrl_q[`BIT_PORTCHG_FLAG],
	                   pin_ctrl_q[`BIT_PIN2_FLAG],
	                   pin_ctrl_q[`BIT_PIN1_FLAG],
	                   pflags1_q, pflags2_q[3:0]};
	assign src_en   = {core_ctrl_q[`BIT_TMR0_EN],
	                   core_ctrl_q[`BIT_PIN0_EN],
	                   core_ctrl_q[`BIT_PORTCHG_EN],
	                   pin_ctrl_q[`BIT_PIN2_EN],
	                   pin_ctrl_q[`BIT_PIN1_EN],
	                   periph_enable_i};
	// Pin 0 has no priority bit and is always high priority
	assign src_prio = {edge_ctrl_q[`BIT_TMR0_PRIO],
	                   1'b1,
	                   edge_ctrl_q[`BIT_PORTCHG_PRIO],
	                   pin_ctrl_q[`BIT_PIN2_PRIO],
	                   pin_ctrl_q[`BIT_PIN1_PRIO],
	                   periph_priority_i};
	assign src_periph = {5'h00, 12'hFFF};

	// Request generation and vector choice
	irq_request_arbiter u_arb (
		.clk_sys_i         (clk_sys_i),
		.rst_i             (rst_i),
		.flag_i            (src_flag),
		.enable_i          (src_en),
		.prio_high_i       (src_prio),
		.is_periph_i       (src_periph),
		.prio_levels_i     (reset_stat_q[`BIT_PRIO_LEVELS_EN]),
		.global_en_i       (core_ctrl_q[`BIT_GLOBAL_EN]),
		.periph_global_en_i(core_ctrl_q[`BIT_PERIPH_GLOBAL_EN]),
		.irq_high_o        (irq_high_o),
		.irq_low_o         (irq_low_o),
		.vector_o          (vector_addr_o)
	);

endmodule

// file: irq_event_source.sv
`timescale 1ns/10ps
// Stand-in for the peripheral event sources; each request leaves one cycle later
module irq_event_source (
	input  wire logic            clk_sys_i,
	input  wire logic [13:0]     fire_i,
	input  wire logic [1:0]      serial_lvl_i,
	output irq_pkg::periph_evt_s evt_o,
	output logic                 timer0_ovf_o,
	output logic                 port_change_o
);
	// Request bits follow the struct order; the serial buffers are levels, never pulses
	always_ff @(posedge clk_sys_i) begin
		evt_o <= (fire_i[11:0] & 12'hCFF) | {2'b00, serial_lvl_i, 8'h00};
		timer0_ovf_o <= fire_i[13];
		port_change_o <= fire_i[12];
	end
endmodule

// file: irq_port_monitor.sv
`timescale 1ns/10ps
`include "irq_consts.svh"
// Port-level checks of the interrupt register block
module irq_port_monitor (
	input wire logic                 clk_sys_i,
	input wire logic                 rst_i,
	input wire irq_pkg::bus_req_s    bus_i,
	input wire irq_pkg::byte_t       rd_data_o,
	input wire irq_pkg::periph_evt_s periph_evt_i,
	input wire logic [7:0]           port_b_latch_i,
	input wire logic [7:0]           port_pullup_en_o,
	input wire logic                 irq_high_o,
	input wire logic                 irq_low_o,
	input wire irq_pkg::vec_addr_t   vector_addr_o
);
	wire logic [1:0] ser_lvl = {periph_evt_i.rx_full, periph_evt_i.tx_empty};
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Holes and reserved bits read back as zero
	a_unmapped_zero: assert property (bus_i.rd && bus_i.addr > 3'h5 |=> rd_data_o == 8'h00)
		else $error("unmapped read gave data");
	a_edge_reserved: assert property (bus_i.rd && bus_i.addr == 3'h0 |=> !rd_data_o[3] && !rd_data_o[1])
		else $error("edge control reserved bit set");
	a_pin_reserved: assert property (bus_i.rd && bus_i.addr == 3'h1 |=> !rd_data_o[5] && !rd_data_o[2])
		else $error("pin control reserved bit set");
	a_status_reserved: assert property (bus_i.rd && bus_i.addr == 3'h2 |=> !rd_data_o[5])
		else $error("status reserved bit set");
	a_flags2_upper: assert property (bus_i.rd && bus_i.addr == 3'h4 |=> rd_data_o[7:4] == 4'h0)
		else $error("flags two upper nibble set");
	// Serial bits mirror the buffer levels when those have been steady
	a_serial_mirror: assert property (bus_i.rd && bus_i.addr == 3'h3 && $stable(ser_lvl) |=> rd_data_o[5:4] == $past(ser_lvl))
		else $error("serial flag bits do not mirror levels");
	// One request level at a time, each with its own vector
	a_single_level: assert property (irq_low_o |-> !irq_high_o)
		else $error("both request levels high");
	a_low_vector: assert property (irq_low_o |-> vector_addr_o == `VEC_LOW)
		else $error("low request with wrong vector");
	a_high_vector: assert property (irq_high_o |-> vector_addr_o == `VEC_HIGH)
		else $error("high request with wrong vector");
	// Enabled pull-ups always copy the latch value of the cycle before
	a_pullup_follow: assert property (port_pullup_en_o != 8'h00 |-> port_pullup_en_o == $past(port_b_latch_i))
		else $error("pull-ups differ from latch");
	c_high: cover property (irq_high_o);
	c_low: cover property (irq_low_o);
	c_flag_read: cover property (bus_i.rd && bus_i.addr == 3'h3);
endmodule

bind interrupt_edge_priority_flags irq_port_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.bus_i(bus_i), .rd_data_o(rd_data_o), .periph_evt_i(periph_evt_i),
	.port_b_latch_i(port_b_latch_i), .port_pullup_en_o(port_pullup_en_o),
	.irq_high_o(irq_high_o), .irq_low_o(irq_low_o), .vector_addr_o(vector_addr_o));

// file: tb_interrupt_edge_priority_flags.sv
`timescale 1ns/10ps
`include "irq_consts.svh"
// Self-checking bench for the interrupt flag, edge and priority registers
module tb_interrupt_edge_priority_flags;
	logic                 clk_sys_i, rst_i, t0, pc, hi, lo;
	irq_pkg::bus_req_s    bus;
	irq_pkg::byte_t       rd_data;
	irq_pkg::periph_evt_s evt;
	irq_pkg::vec_addr_t   vec;
	logic [2:0]           pins;
	logic [13:0]          fire;
	logic [1:0]           lvl;
	logic [11:0]          pen, ppr;
	logic [7:0]           latch, pull;
	logic [10:0]          lv;
	logic [31:0]          rs;
	int                   n_fail, cmp_count;
	logic [7:0]           rv [8] = '{8'hF5, 8'hC0, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]           msk [8] = '{8'hF5, 8'hDB, 8'hDF, 8'hCF, 8'h0F, 8'hFF, 8'h00, 8'h00};

	interrupt_edge_priority_flags DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus),
		.rd_data_o(rd_data), .ext_pin_i(pins), .timer0_ovf_i(t0), .port_change_i(pc),
		.periph_evt_i(evt), .periph_enable_i(pen), .periph_priority_i(ppr),
		.port_b_latch_i(latch), .port_pullup_en_o(pull), .irq_high_o(hi), .irq_low_o(lo),
		.vector_addr_o(vec));
	irq_event_source u_src (.clk_sys_i(clk_sys_i), .fire_i(fire), .serial_lvl_i(lvl),
		.evt_o(evt), .timer0_ovf_o(t0), .port_change_o(pc));

	// 40 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Where each event source lands: register offset and flag mask
	function automatic logic [10:0] loc(input int k);
		if (k > 11) return {3'h5, (k == 13) ? 8'h04 : 8'h01};
		if (k > 3) return {3'h3, 8'h01 << (k - 4)};
		return {3'h4, 8'h01 << k};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Write strobe also ends any pending event request
	task automatic bw(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		bus <= '{a, d, 1'b1, 1'b0};
		fire <= '0;
		@(posedge clk_sys_i);
		bus <= '0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys_i);
		bus <= '0;
		@(negedge clk_sys_i);
		chk(32'(rd_data), 32'(e));
		@(posedge clk_sys_i); // Callers then drive inputs on a rising edge
	endtask

	task automatic pulse(input int k);
		@(posedge clk_sys_i);
		fire <= 14'h0001 << k;
		@(posedge clk_sys_i);
		fire <= '0;
	endtask

	// Covers pin synchroniser, flag and request flop latency
	task automatic settle();
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask

	task automatic irq(input logic [22:0] e);
		settle();
		chk(32'({hi, lo, vec}), 32'(e));
		@(posedge clk_sys_i);
	endtask

	task automatic rst_chk();
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 8; a++) rc(a[2:0], rv[a]);
		$display("test reset values done");
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, far beyond the well under a thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_fail++;
		final_report();
	end

	initial begin
		rst_i = 1'b1;
		bus = '0;
		pins = 3'h0;
		fire = '0;
		lvl = 2'b00;
		pen = '0;
		ppr = '0;
		latch = 8'h00;
		rs = 32'h82a0;
		n_fail = 0;
		cmp_count = 0;
		rst_chk();
		// Random writes everywhere, masked readback, then a second reset
		for (int i = 0; i < 6; i++) begin
			for (int a = 0; a < 8; a++) begin
				rs = lfsr(rs);
				latch <= rs[15:8];
				bw(a[2:0], rs[7:0]);
				rc(a[2:0], rs[7:0] & msk[a]);
			end
		end
		$display("test random access done");
		rst_chk();
		rs = lfsr(rs);
		latch <= rs[7:0] | 8'h01;
		bw(3'h0, 8'h75);
		settle();
		chk(32'(pull), 32'(latch));
		bw(3'h0, 8'hF5);
		settle();
		chk(32'(pull), 32'h0);
		// Every event source except the two serial levels (k 8 and 9) sets its flag with all enables off
		for (int k = 0; k < 14; k++) begin
			if (k == 8 || k == 9) continue;
			bw(3'h3, 8'h00);
			bw(3'h4, 8'h00);
			bw(3'h5, 8'h00);
			pulse(k);
			lv = loc(k);
			rc(lv[10:8], lv[7:0]);
		end
		@(posedge clk_sys_i);
		fire <= 14'h0400;
		bw(3'h3, 8'h00);
		rc(3'h3, 8'h40);
		lvl <= 2'b11;
		bw(3'h3, 8'h00);
		settle();
		rc(3'h3, 8'h30);
		lvl <= 2'b10;
		settle();
		rc(3'h3, 8'h20);
		lvl <= 2'b00;
		$display("test event flags done");
		// Each pin, both edge selections, selected and opposite edge
		for (int p = 0; p < 3; p++) begin
			for (int r = 0; r < 2; r++) begin
				bw(3'h0, r ? 8'hF5 : 8'h85);
				pins[p] <= ~r[0];
				settle();
				bw(3'h1, 8'hC0);
				bw(3'h5, 8'h00);
				pins[p] <= r[0];
				settle();
				rc(p ? 3'h1 : 3'h5, p ? 8'hC0 | (8'h01 << (p - 1)) : 8'h02);
				bw(3'h1, 8'hC0);
				bw(3'h5, 8'h00);
				pins[p] <= ~r[0];
				settle();
				rc(p ? 3'h1 : 3'h5, p ? 8'hC0 : 8'h00);
			end
		end
		$display("test external pins done");
		bw(3'h0, 8'hF5);
		bw(3'h5, 8'h00);
		bw(3'h5, 8'hA0);
		pulse(13);
		irq({2'b10, `VEC_HIGH});
		bw(3'h5, 8'h00);
		pen <= 12'h400;
		pulse(10);
		bw(3'h5, 8'h80);
		irq({2'b00, `VEC_HIGH});
		bw(3'h5, 8'hC0);
		irq({2'b10, `VEC_HIGH});
		bw(3'h2, 8'h9C);
		irq({2'b01, `VEC_LOW});
		ppr <= 12'h400;
		irq({2'b10, `VEC_HIGH});
		pen <= 12'h000;
		bw(3'h0, 8'hF1);
		bw(3'h5, 8'hE4);
		irq({2'b01, `VEC_LOW});
		bw(3'h0, 8'hF5);
		irq({2'b10, `VEC_HIGH});
		$display("test requests done");
		final_report();
	end
endmodule
